/* File: link_partner.sv */
// Far-side logic device that clocks words into the link.
`timescale 1ns/1ps
module link_partner (
   output reg clk_out,
   output reg data_out
);
   // The clock rests low between frames; the data line idles high as if pulled up.
   initial begin
      clk_out = 1'b0;
      data_out = 1'b1;
   end
   task send_word(input [3:0] w);
      integer i;
      begin
         for (i = 3; i >= 0; i = i - 1) begin
            data_out = w[i];
            #200 clk_out = 1'b1;
            #200 clk_out = 1'b0;
         end
         data_out = 1'b1;
      end
   endtask
   task hold_low(input integer ns);
      begin
         data_out = 1'b0;
         #(ns) data_out = 1'b1;
      end
   endtask
endmodule // link_partner

/* File: shift_link.v */
// Serial shift link: shift register, pulse burst generator, pattern source.
// Notes on behaviour
// - Start rising edge opens burst window until programmed pulse count is reached.
// - Window counter counts the generator's own output pulses.
// - Generator toggles after a programmed delay on both edges; delay sets period.
// - Generator only toggles while window is high; stops when window falls.
// - Pulse timing restarts at every new transaction.
// - Each shift clock rising edge moves every stage into the next; four stages.
// - Every stage is visible as a parallel output bit.
// - One active-low clear wipes all stages together.
// - Per-stage selector picks load value over predecessor; an edge commits it.
// - Load enable also acts as stage clock, committing the load.
// - External-clock receive shifts on the partner's clock input.
// - Internal-clock receive starts when data is held low for a set time.
// - Internal-clock receive emits exactly as many pulses as there are stages.
// - Parallel-to-serial selects load or shift per stage; data and clock out.
// - Bidirectional mode: this device always transmits first.
// - Transmit-enable flop gates transmit clock and drives pin output enables.
// - Counter on transmit clock detects done; edge detector clears transmit enable.
// - Transmit clock made internally by a resetting counter; feeds pattern and pin.
// - Received bits shift in on the partner's clock, not the internal one.
// - Outgoing bits come from a host-writable pattern source.
// - Received contents are readable by the host.
`timescale 1ns/1ps
`include "shift_link_consts.vh"
module shift_link #(
   parameter STAGES = `STAGES_DEF,
   parameter PATTERN_BITS = `PATTERN_BITS_DEF,
   parameter HALF_CYC = `HALF_PERIOD_CYC,
   parameter START_CYC = `START_LOW_CYC
) (
   input wire CLK_IN,
   input wire RST_IN,
   input wire [1:0] MODE_IN,
   input wire START_IN,
   input wire STAGE_CLEAR_N_IN,
   input wire LOAD_EN_IN,
   input wire [STAGES-1:0] LOAD_DATA_IN,
   input wire [4:0] BURST_COUNT_IN,
   input wire [PATTERN_BITS-1:0] PATTERN_IN,
   input wire PATTERN_WE_IN,
   input wire LINK_CLK_IN,
   input wire DATA_IN,
   output wire DATA_OUT,
   output wire DATA_OE_N_OUT,
   output wire LINK_CLK_OUT,
   output wire LINK_CLK_OE_N_OUT,
   output wire BURST_WINDOW_OUT,
   output wire [STAGES-1:0] PARALLEL_OUT,
   output wire [STAGES-1:0] RX_WORD_OUT,
   output wire RX_VALID_OUT,
   input wire RX_READY_IN,
   output wire RX_OVERRUN_OUT,
   output wire BUSY_OUT
);
   // -------------------------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------------------------
   reg [3:0] sync1_q;
   reg [3:0] sync2_q;
   reg lclk_prev_q;
   reg start_prev_q;
   wire lclk_s = sync2_q[0];
   wire data_s = sync2_q[1];
   wire start_s = sync2_q[2];
   wire clr_n_s = sync2_q[3];
   wire lclk_rise = lclk_s && !lclk_prev_q;

   always @(posedge CLK_IN) begin
      if (RST_IN) begin
         // Reset values match the idle pin levels, so no false edge follows reset.
         sync1_q <= 4'ha;
         sync2_q <= 4'ha;
         lclk_prev_q <= 1'b0;
         start_prev_q <= 1'b0;
      end else begin
         sync1_q <= {STAGE_CLEAR_N_IN, START_IN, DATA_IN, LINK_CLK_IN};
         sync2_q <= sync1_q;
         lclk_prev_q <= lclk_s;
         start_prev_q <= start_s;
      end
   end

   // -------------------------------------------------------------------------
   // Receive trigger: data held low for the set time
   // -------------------------------------------------------------------------
   reg [7:0] low_cnt_q;
   reg low_seen_q;
   wire low_trig = (low_cnt_q == START_CYC[7:0] - 8'h01) && !data_s;

   always @(posedge CLK_IN) begin
      if (RST_IN) begin
         low_cnt_q <= 8'h00;
         low_seen_q <= 1'b0;
      end else if (data_s || MODE_IN != `MODE_S2P_INT) begin
         low_cnt_q <= 8'h00;
         low_seen_q <= 1'b0;
      end else if (!low_seen_q) begin
         low_cnt_q <= low_cnt_q + 8'h01;
         if (low_trig) begin
            low_seen_q <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Burst generator: window one-shot plus period delay cell
   // -------------------------------------------------------------------------
   reg window_q;
   reg gen_clk_q;
   reg [7:0] period_delay_cell_q;
   reg [4:0] burst_window_counter_q;
   reg [4:0] target_q;
   wire start_rise = start_s && !start_prev_q;
   wire burst_go = start_rise || low_trig;
   wire half_done = (period_delay_cell_q == HALF_CYC[7:0] - 8'h01);
   wire gen_rise = window_q && half_done && !gen_clk_q;
   wire [4:0] burst_n = (MODE_IN == `MODE_S2P_INT) ? STAGES[4:0] : BURST_COUNT_IN;

   always @(posedge CLK_IN) begin
      if (RST_IN) begin
         window_q <= 1'b0;
         gen_clk_q <= 1'b0;
         period_delay_cell_q <= 8'h00;
         burst_window_counter_q <= 5'h00;
         target_q <= 5'h00;
      end else if (burst_go && !window_q && burst_n != 5'h00) begin
         window_q <= 1'b1;
         target_q <= burst_n;
         gen_clk_q <= 1'b0;
         period_delay_cell_q <= 8'h00;
         burst_window_counter_q <= 5'h00;
      end else if (window_q) begin
         if (half_done) begin
            period_delay_cell_q <= 8'h00;
            gen_clk_q <= !gen_clk_q;
         end else begin
            period_delay_cell_q <= period_delay_cell_q + 8'h01;
         end
         // The window falls at the falling edge so the last pulse is whole.
         if (half_done && gen_clk_q && burst_window_counter_q == target_q) begin
            window_q <= 1'b0;
         end
         if (gen_rise) begin
            burst_window_counter_q <= burst_window_counter_q + 5'h01;
         end
      end else begin
         gen_clk_q <= 1'b0;
         period_delay_cell_q <= 8'h00;
      end
   end

   // -------------------------------------------------------------------------
   // Shift register with per-stage load selector
   // -------------------------------------------------------------------------
   reg [STAGES-1:0] stage_q;
   reg load_prev_q;
   reg serial_out_q;
   wire load_commit = LOAD_EN_IN && !load_prev_q;
   wire ext_clk_mode = (MODE_IN == `MODE_S2P_EXT) || (MODE_IN == `MODE_BIDIR);
   wire shift_edge = ext_clk_mode ? lclk_rise : gen_rise;
   wire serial_in = (MODE_IN == `MODE_P2S) ? 1'b0 : data_s;
   wire [STAGES-1:0] stage_d;

   genvar gi;
   generate
      for (gi = 0; gi < STAGES; gi = gi + 1) begin : g_stage
         if (gi == 0) begin : g_first
            assign stage_d[gi] = LOAD_EN_IN ? LOAD_DATA_IN[gi] : serial_in;
         end else begin : g_rest
            assign stage_d[gi] = LOAD_EN_IN ? LOAD_DATA_IN[gi] : stage_q[gi-1];
         end
      end
   endgenerate

   always @(posedge CLK_IN) begin
      if (RST_IN || !clr_n_s) begin
         stage_q <= {STAGES{1'b0}};
         load_prev_q <= 1'b0;
         serial_out_q <= 1'b0;
      end else begin
         load_prev_q <= LOAD_EN_IN;
         if (load_commit || (shift_edge && !LOAD_EN_IN)) begin
            stage_q <= stage_d;
            serial_out_q <= stage_q[STAGES-1];
         end
      end
   end

   assign PARALLEL_OUT = stage_q;

   // -------------------------------------------------------------------------
   // Received words to the host through the FIFO
   // -------------------------------------------------------------------------
   reg [2:0] bit_cnt_q;
   reg word_push_q;
   reg [STAGES-1:0] word_q;
   reg overrun_q;
   wire fifo_ready;

   always @(posedge CLK_IN) begin
      if (RST_IN || !clr_n_s) begin
         bit_cnt_q <= 3'h0;
         word_push_q <= 1'b0;
         word_q <= {STAGES{1'b0}};
         overrun_q <= 1'b0;
      end else begin
         word_push_q <= 1'b0;
         if (shift_edge && !LOAD_EN_IN && MODE_IN != `MODE_P2S) begin
            if (bit_cnt_q == STAGES[2:0] - 3'h1) begin
               bit_cnt_q <= 3'h0;
               word_push_q <= 1'b1;
               word_q <= stage_d;
            end else begin
               bit_cnt_q <= bit_cnt_q + 3'h1;
            end
         end
         // Back-pressure: a full FIFO drops the word and the overrun flag holds.
         if (word_push_q && !fifo_ready) begin
            overrun_q <= 1'b1;
         end
      end
   end

   assign RX_OVERRUN_OUT = overrun_q;

   word_fifo #(
      .WIDTH(STAGES),
      .DEPTH(`FIFO_DEPTH_DEF),
      .AW(3)
   ) u_rx_fifo (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .wr_data_in(word_q),
      .wr_valid_in(word_push_q),
      .wr_ready_out(fifo_ready),
      .rd_data_out(RX_WORD_OUT),
      .rd_valid_out(RX_VALID_OUT),
      .rd_ready_in(RX_READY_IN)
   );

   // -------------------------------------------------------------------------
   // Transmit path: pattern source and transmit-enable flop
   // -------------------------------------------------------------------------
   reg [PATTERN_BITS-1:0] pattern_source_q;
   reg [PATTERN_BITS-1:0] tx_shift_q;
   reg tx_en_q;
   reg window_prev_q;
   reg tx_bit_q;
   wire bidir = (MODE_IN == `MODE_BIDIR);
   wire window_fall = window_prev_q && !window_q;

   always @(posedge CLK_IN) begin
      if (RST_IN) begin
         pattern_source_q <= `PATTERN_RST;
         tx_shift_q <= `PATTERN_RST;
         tx_en_q <= 1'b0;
         window_prev_q <= 1'b0;
         tx_bit_q <= 1'b0;
      end else begin
         window_prev_q <= window_q;
         if (PATTERN_WE_IN) begin
            pattern_source_q <= PATTERN_IN;
         end
         if (bidir && burst_go && !window_q && burst_n != 5'h00) begin
            tx_en_q <= 1'b1;
            tx_shift_q <= pattern_source_q;
            tx_bit_q <= pattern_source_q[PATTERN_BITS-1];
         end else if (window_fall) begin
            tx_en_q <= 1'b0;
         end else if (tx_en_q && half_done && gen_clk_q) begin
            // Data changes on the falling edge so the partner samples on rising.
            tx_shift_q <= {tx_shift_q[PATTERN_BITS-2:0], 1'b0};
            tx_bit_q <= tx_shift_q[PATTERN_BITS-2];
         end
      end
   end

   // -------------------------------------------------------------------------
   // Pins
   // -------------------------------------------------------------------------
   wire p2s = (MODE_IN == `MODE_P2S);
   wire drive_clk = (tx_en_q && bidir) || (p2s && window_q);

   assign DATA_OUT = bidir ? tx_bit_q : serial_out_q;
   assign DATA_OE_N_OUT = !((tx_en_q && bidir) || p2s);
   assign LINK_CLK_OUT = drive_clk & gen_clk_q;
   assign LINK_CLK_OE_N_OUT = !drive_clk;
   assign BURST_WINDOW_OUT = window_q;
   assign BUSY_OUT = window_q || tx_en_q;
endmodule // shift_link

/* File: shift_link_consts.vh */
// Constants for the serial shift link with pulse burst generator.
`ifndef SHIFT_LINK_CONSTS_VH
`define SHIFT_LINK_CONSTS_VH

// ----------------------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------------------
`define STAGES_DEF 4
`define PATTERN_BITS_DEF 16
`define FIFO_DEPTH_DEF 8
`define CLK_NS 50
// Half period of the generated clock, in ns, and its cycle count (rounded down).
`define HALF_PERIOD_NS 500
`define HALF_PERIOD_CYC ((`HALF_PERIOD_NS) / (`CLK_NS))
// Least low time on the data line that starts an internal-clock receive.
`define START_LOW_NS 2000
`define START_LOW_CYC (((`START_LOW_NS) + (`CLK_NS) - 1) / (`CLK_NS))

// ----------------------------------------------------------------------------
// Modes and reset values
// ----------------------------------------------------------------------------
`define MODE_S2P_EXT 2'h0
`define MODE_S2P_INT 2'h1
`define MODE_P2S 2'h2
`define MODE_BIDIR 2'h3
`define PATTERN_RST 16'h0000

`endif

/* File: shift_link_props.sv */
// Concurrent checks on the shift link's top ports.
`timescale 1ns/1ps
module shift_link_props #(
   parameter STAGES = 4,
   parameter HALF_CYC = 10
) (
   input wire CLK_IN,
   input wire RST_IN,
   input wire [1:0] MODE_IN,
   input wire START_IN,
   input wire STAGE_CLEAR_N_IN,
   input wire LOAD_EN_IN,
   input wire [STAGES-1:0] LOAD_DATA_IN,
   input wire [4:0] BURST_COUNT_IN,
   input wire DATA_OE_N_OUT,
   input wire LINK_CLK_OUT,
   input wire LINK_CLK_OE_N_OUT,
   input wire BURST_WINDOW_OUT,
   input wire [STAGES-1:0] PARALLEL_OUT,
   input wire RX_OVERRUN_OUT,
   input wire BUSY_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);
   // ---------------------------------------------------------------
   // Helper counters
   // ---------------------------------------------------------------
   // High time and pulses per window are counted here, so the checks stay short.
   reg [7:0] hi_q;
   reg [5:0] rise_q;
   reg clk_q;
   reg [9:0] win_q;
   always @(posedge CLK_IN) begin
      clk_q <= LINK_CLK_OUT;
      win_q <= (RST_IN || !BURST_WINDOW_OUT) ? 10'h000 : win_q + 10'h001;
      hi_q <= (RST_IN || !LINK_CLK_OUT) ? 8'h00 : hi_q + 8'h01;
      rise_q <= (RST_IN || !BURST_WINDOW_OUT) ? 6'h00 :
         rise_q + {5'h00, LINK_CLK_OUT && !clk_q};
   end
   a_idle_clk_low: assert property (!BUSY_OUT |-> !LINK_CLK_OUT)
      else $error("generated clock active while idle");
   a_start_opens: assert property ($rose(START_IN) && !BUSY_OUT && MODE_IN[1]
      && BURST_COUNT_IN != 5'h00 |-> ##[1:6] BURST_WINDOW_OUT)
      else $error("start edge did not open the window");
   a_first_half: assert property ($rose(BURST_WINDOW_OUT) |-> !LINK_CLK_OUT[*2])
      else $error("burst did not start with a fresh low half");
   a_half_period: assert property ($fell(LINK_CLK_OUT) |-> hi_q == HALF_CYC)
      else $error("generated high half has wrong length");
   a_pulse_count: assert property ($fell(BURST_WINDOW_OUT) && MODE_IN[1] |->
      rise_q == BURST_COUNT_IN)
      else $error("wrong pulse count in window");
   // The internal-clock burst never reaches a pin, so its length is checked instead.
   a_int_length: assert property ($fell(BURST_WINDOW_OUT) && MODE_IN == 2'h1 |->
      win_q == 2 * HALF_CYC * STAGES)
      else $error("internal burst has wrong length");
   a_busy_ends: assert property ($fell(BURST_WINDOW_OUT) |-> ##[0:4] !BUSY_OUT)
      else $error("transfer did not end after window");
   a_tx_oe: assert property (MODE_IN == 2'h3 && BURST_WINDOW_OUT |->
      !DATA_OE_N_OUT && !LINK_CLK_OE_N_OUT)
      else $error("pins not driven during transmit");
   a_clear_stages: assert property (!STAGE_CLEAR_N_IN[*5] |-> PARALLEL_OUT == '0)
      else $error("stages not cleared");
   a_load_commit: assert property ($rose(LOAD_EN_IN) && STAGE_CLEAR_N_IN && !BUSY_OUT
      |-> ##[1:3] PARALLEL_OUT == LOAD_DATA_IN)
      else $error("load value not committed");
   c_burst: cover property ($rose(BURST_WINDOW_OUT));
   c_overrun: cover property ($rose(RX_OVERRUN_OUT));
   c_transmit: cover property (MODE_IN == 2'h3 && BURST_WINDOW_OUT);
endmodule // shift_link_props

bind shift_link shift_link_props #(.STAGES(STAGES), .HALF_CYC(HALF_CYC)) chk (
   .CLK_IN(CLK_IN), .RST_IN(RST_IN), .MODE_IN(MODE_IN), .START_IN(START_IN),
   .STAGE_CLEAR_N_IN(STAGE_CLEAR_N_IN), .LOAD_EN_IN(LOAD_EN_IN), .LOAD_DATA_IN(LOAD_DATA_IN),
   .BURST_COUNT_IN(BURST_COUNT_IN), .DATA_OE_N_OUT(DATA_OE_N_OUT), .LINK_CLK_OUT(LINK_CLK_OUT),
   .LINK_CLK_OE_N_OUT(LINK_CLK_OE_N_OUT), .BURST_WINDOW_OUT(BURST_WINDOW_OUT),
   .PARALLEL_OUT(PARALLEL_OUT), .RX_OVERRUN_OUT(RX_OVERRUN_OUT), .BUSY_OUT(BUSY_OUT));

/* File: shift_link_test.sv */
// Self-checking bench for the shift link.
`timescale 1ns/1ps
module shift_link_test;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [1:0] mode = 2'h2;
   reg start = 1'b0;
   reg clr_n = 1'b1;
   reg load_en = 1'b0;
   reg [3:0] load_data = 4'h0;
   reg [4:0] count = 5'h03;
   reg [15:0] pattern = 16'h0000;
   reg pattern_we = 1'b0;
   reg rd_ready = 1'b0;
   wire p_clk, p_data, data_out, data_oe_n, gen_clk, gen_oe_n, window, busy, valid, ovr;
   wire [3:0] par, word;
   integer bad_count = 0;
   integer n_tests = 0;
   integer i;
   // Each shared pin carries whichever side has its enable asserted.
   wire link_in = gen_oe_n ? p_clk : gen_clk;
   wire data_line = data_oe_n ? p_data : data_out;
   always #25 clk = ~clk;
   shift_link #(.HALF_CYC(4), .START_CYC(8)) uut (
      .CLK_IN(clk), .RST_IN(rst), .MODE_IN(mode), .START_IN(start),
      .STAGE_CLEAR_N_IN(clr_n), .LOAD_EN_IN(load_en), .LOAD_DATA_IN(load_data),
      .BURST_COUNT_IN(count), .PATTERN_IN(pattern), .PATTERN_WE_IN(pattern_we),
      .LINK_CLK_IN(link_in), .DATA_IN(data_line), .DATA_OUT(data_out),
      .DATA_OE_N_OUT(data_oe_n), .LINK_CLK_OUT(gen_clk), .LINK_CLK_OE_N_OUT(gen_oe_n),
      .BURST_WINDOW_OUT(window), .PARALLEL_OUT(par), .RX_WORD_OUT(word),
      .RX_VALID_OUT(valid), .RX_READY_IN(rd_ready), .RX_OVERRUN_OUT(ovr), .BUSY_OUT(busy));
   link_partner peer (.clk_out(p_clk), .data_out(p_data));
   task end_sim;
      begin
         if (bad_count == 0 && n_tests > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task check(input [39:0] name, input [15:0] seen, input [15:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("wrong value %0s: expected %h, seen %h", name, exp, seen);
         end
      end
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // Waits are bounded; a hang counts as a mismatch and ends the run.
   task wait_for(input [1:0] sel, input v);
      integer n;
      begin
         n = 0;
         while (n < 400 && (sel == 2'h0 ? window : sel == 2'h1 ? busy :
               sel == 2'h2 ? valid : gen_clk) !== v) begin
            @(posedge clk);
            #1 n = n + 1;
         end
         if (n == 400) begin
            bad_count = bad_count + 1;
            end_sim;
         end
      end
   endtask
   task pop(input [3:0] exp);
      begin
         wait_for(2'h2, 1'b1);
         check("word", word, exp);
         @(posedge clk) rd_ready <= 1'b1;
         @(posedge clk) rd_ready <= 1'b0;
         #1;
      end
   endtask
   task t_burst(input [4:0] n);
      integer k;
      begin
         @(posedge clk) count <= n;
         start <= 1'b1;
         wait_for(2'h0, 1'b1);
         for (k = 0; k < n; k = k + 1) begin
            wait_for(2'h3, 1'b1);
            wait_for(2'h3, 1'b0);
         end
         repeat (5) @(posedge clk);
         #1 check("win", window, 1'b0);
         for (k = 0; k < 8; k = k + 1) begin
            @(posedge clk);
            #1 check("idle", gen_clk, 1'b0);
         end
         start <= 1'b0;
      end
   endtask
   task t_load;
      integer k;
      begin
         @(posedge clk) load_data <= 4'ha;
         load_en <= 1'b1;
         repeat (3) @(posedge clk);
         #1 check("load", par, 4'ha);
         @(posedge clk) load_en <= 1'b0;
         count <= 5'h04;
         start <= 1'b1;
         for (k = 0; k < 4; k = k + 1) begin
            wait_for(2'h3, 1'b1);
            check("p2s", data_out, load_data[3 - k]);
            wait_for(2'h3, 1'b0);
         end
         wait_for(2'h1, 1'b0);
         check("shout", par, 4'h0);
         @(posedge clk) start <= 1'b0;
         load_en <= 1'b1;
         repeat (3) @(posedge clk);
         @(posedge clk) load_en <= 1'b0;
         clr_n <= 1'b0;
         repeat (5) @(posedge clk);
         #1 check("clr", par, 4'h0);
         @(posedge clk) clr_n <= 1'b1;
         mode <= 2'h0;
         repeat (3) @(posedge clk);
      end
   endtask
   task t_rx;
      begin
         #13 peer.send_word(4'hb);
         wait_for(2'h2, 1'b1);
         check("par", par, 4'hb);
         pop(4'hb);
      end
   endtask
   task t_fill;
      begin
         #12;
         for (i = 0; i < 9; i = i + 1)
            peer.send_word(i[3:0]);
         repeat (4) @(posedge clk);
         #1 check("ovr", ovr, 1'b1);
         for (i = 0; i < 8; i = i + 1)
            pop(i[3:0]);
         repeat (2) @(posedge clk);
         #1 check("empty", valid, 1'b0);
      end
   endtask
   task t_int;
      begin
         @(posedge clk) mode <= 2'h1;
         repeat (3) @(posedge clk);
         #13 peer.hold_low(550);
         wait_for(2'h0, 1'b1);
         wait_for(2'h0, 1'b0);
         pop(4'hf);
      end
   endtask
   task t_tx;
      integer k;
      begin
         @(posedge clk) mode <= 2'h3;
         pattern <= 16'hb38d;
         pattern_we <= 1'b1;
         count <= 5'h04;
         @(posedge clk) pattern_we <= 1'b0;
         start <= 1'b1;
         wait_for(2'h0, 1'b1);
         check("oe", data_oe_n, 1'b0);
         for (k = 15; k > 11; k = k - 1) begin
            wait_for(2'h3, 1'b1);
            check("tx", data_out, pattern[k]);
            wait_for(2'h3, 1'b0);
         end
         wait_for(2'h1, 1'b0);
         check("oe", data_oe_n, 1'b1);
         start <= 1'b0;
      end
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check("clkoe", gen_oe_n, 1'b1);
      t_burst(5'h03);
      t_burst(5'h01);
      t_load;
      t_rx;
      t_fill;
      t_int;
      t_tx;
      end_sim;
   end
endmodule // shift_link_test

/* File: word_fifo.v */
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module word_fifo #(
   parameter WIDTH = 4,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire clk_in,
   input wire rst_in,
   input wire [WIDTH-1:0] wr_data_in,
   input wire wr_valid_in,
   output wire wr_ready_out,
   output wire [WIDTH-1:0] rd_data_out,
   output wire rd_valid_out,
   input wire rd_ready_in
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0] cnt_q;
   wire do_wr;
   wire do_rd;

   assign wr_ready_out = (cnt_q != DEPTH[AW:0]);
   assign rd_valid_out = (cnt_q != {(AW+1){1'b0}});
   assign rd_data_out = mem[rp_q];
   assign do_wr = wr_valid_in && wr_ready_out;
   assign do_rd = rd_valid_out && rd_ready_in;

   always @(posedge clk_in) begin
      if (do_wr) begin
         mem[wp_q] <= wr_data_in;
      end
   end

   always @(posedge clk_in) begin
      if (rst_in) begin
         wp_q <= {AW{1'b0}};
         rp_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
         end
         if (do_rd) begin
            rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
         end
         if (do_wr && !do_rd) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (do_rd && !do_wr) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // word_fifo
